/* verilog/lf_status_pkg.sv */
// package: register map, field positions, reset values and types of the lf receiver status block
package lf_status_pkg;

  // ------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] STATUS_OFFSET = 8'h00;
  localparam logic [7:0] CONTROL_OFFSET = 8'h04;
  localparam logic [7:0] DATA_OFFSET = 8'h08;
  localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h0C;

  // ------------------------------------------------------------
  // status register field positions
  // ------------------------------------------------------------
  localparam int DATA_READY_BIT = 7;
  localparam int RECEIVE_ERROR_BIT = 6;
  localparam int CARRIER_DETECT_BIT = 5;
  localparam int ID_MATCH_BIT = 4;
  localparam int OVERFLOW_BIT = 3;
  localparam int END_OF_MESSAGE_BIT = 2;
  localparam int LOW_POWER_SNIFF_BIT = 1;
  localparam int ACKNOWLEDGE_BIT = 0;

  // ------------------------------------------------------------
  // control register field positions
  // ------------------------------------------------------------
  localparam int PAGE_SELECT_BIT = 0;
  localparam int CARRIER_MODE_BIT = 1;
  localparam int DECODER_ENABLE_BIT = 2;
  localparam int TOGGLE_MODE_BIT = 3;

  // ------------------------------------------------------------
  // irq enable register field positions
  // ------------------------------------------------------------
  localparam int DATA_READY_IE_BIT = 0;
  localparam int ERROR_IE_BIT = 1;
  localparam int ID_MATCH_IE_BIT = 2;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [5:0] FLAGS_RESET = 6'h00;
  localparam logic LOW_POWER_SNIFF_RESET = 1'b1;
  localparam logic [3:0] CONTROL_RESET = 4'h4;
  localparam logic [2:0] IRQ_ENABLE_RESET = 3'h0;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int SNIFF_EXTRA_US = 200;
  localparam int CLOCK_MHZ = 100;
  localparam int SNIFF_EXTRA_CYCLES = SNIFF_EXTRA_US * CLOCK_MHZ;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic data_ready;
    logic receive_error;
    logic carrier_detect;
    logic id_match;
    logic overflow;
    logic end_of_message;
  } event_flags_t;

  typedef struct packed {
    logic byte_done;
    logic manchester_error;
    logic carrier_valid;
    logic id_match;
    logic eom_error;
  } rx_events_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_READ = 2'b10
  } bus_phase_t;

endpackage : lf_status_pkg

/* verilog/lf_sniff_delay.sv */
// module: stretches the carrier-to-data transition when low power sniff is on
`timescale 1ns/1ps
module lf_sniff_delay #(
  parameter int EXTRA_CYCLES = lf_status_pkg::SNIFF_EXTRA_CYCLES
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // control
  input wire logic i_low_power_sniff,
  input wire logic i_transition_req,
  // result
  output logic o_transition_done
);

  localparam int CW = $clog2(EXTRA_CYCLES + 1);

  logic [CW-1:0] count_q;
  logic busy_q;

  // ------------------------------------------------------------
  // delay counter
  // ------------------------------------------------------------
  // fast path registers done on the edge that takes the request; slow path waits EXTRA_CYCLES more
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      count_q <= '0;
      busy_q <= 1'b0;
      o_transition_done <= 1'b0;
    end else begin
      o_transition_done <= 1'b0;
      if (!busy_q && i_transition_req) begin
        if (i_low_power_sniff) begin
          busy_q <= 1'b1;
          count_q <= CW'(EXTRA_CYCLES - 1);
        end else begin
          o_transition_done <= 1'b1;
        end
      end else if (busy_q) begin
        if (count_q == '0) begin
          busy_q <= 1'b0;
          o_transition_done <= 1'b1;
        end else begin
          count_q <= count_q - 1'b1;
        end
      end
    end
  end

endmodule : lf_sniff_delay

/* verilog/lf_receiver_status_flags.sv */
// module: lf receiver status flags with acknowledge, reached over ahb-lite
// ------------------------------------------------------------
// Functional notes
// - data ready flag, bit 7, sets when a complete byte is assembled
// - data ready clears on acknowledge write or received data read
// - receive error flag, bit 6, sets on bad manchester bit in data mode
// - error, overflow, end-of-message stay clear in carrier detect mode
// - carrier detect flag, bit 5, sets when validation count reached
// - validation count function unused while toggle mode is one
// - id match flag, bit 4, sets on id match, data bits optional
// - interrupt when data ready, error or id flag set and enabled
// - overflow flag, bit 3, sets when new byte overwrites unread byte
// - overflow flag gives no interrupt of its own
// - end-of-message flag, bit 2, sets on eom error after stored byte
// - end-of-message flag gives no interrupt of its own
// - low power sniff bit 1: one saves power, adds 200 us transition
// - low power sniff bit is set by reset
// - acknowledge bit 0 written one clears all six flags
// - acknowledge self-clears next edge and always reads zero
// - writing zero to acknowledge does nothing; reset leaves it alone
// - status register reachable only while page select is zero
// - flags clear on reset; software writes never set them
// - carrier mode select zero means data mode, else carrier detect
// - decoder disabled stops data, error and id flags
// ------------------------------------------------------------
`timescale 1ns/1ps
module lf_receiver_status_flags #(
  parameter int SNIFF_CYCLES = lf_status_pkg::SNIFF_EXTRA_CYCLES
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // receiver events and data
  input wire lf_status_pkg::rx_events_t i_rx_events,
  input wire logic [7:0] i_rx_byte,
  input wire logic i_transition_req,
  // results
  output logic o_irq,
  output logic o_transition_done,
  output logic [3:0] o_control
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  lf_status_pkg::event_flags_t flags_q;
  logic low_power_sniff_q;
  logic [3:0] control_q;
  logic [2:0] irq_en_q;
  logic [7:0] rx_data_q;
  lf_status_pkg::bus_phase_t phase_q;
  logic [7:0] addr_q;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // ------------------------------------------------------------
  // bus address phase capture
  // ------------------------------------------------------------
  logic take;
  assign take = i_hsel && i_hready && i_htrans[1];
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      phase_q <= lf_status_pkg::BUS_IDLE;
      addr_q <= 8'h00;
    end else if (take) begin
      phase_q <= i_hwrite ? lf_status_pkg::BUS_WRITE : lf_status_pkg::BUS_READ;
      addr_q <= i_haddr[7:0];
    end else begin
      phase_q <= lf_status_pkg::BUS_IDLE;
    end
  end

  logic page0;
  logic wr_phase;
  logic rd_phase;
  logic status_wr;
  logic data_rd;
  assign page0 = !control_q[lf_status_pkg::PAGE_SELECT_BIT];
  assign wr_phase = (phase_q == lf_status_pkg::BUS_WRITE);
  assign rd_phase = (phase_q == lf_status_pkg::BUS_READ);
  assign status_wr = wr_phase && page0 && hit(addr_q, lf_status_pkg::STATUS_OFFSET);
  assign data_rd = rd_phase && page0 && hit(addr_q, lf_status_pkg::DATA_OFFSET);

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  logic data_mode;
  logic decoder_on;
  logic count_ok;
  assign data_mode = !control_q[lf_status_pkg::CARRIER_MODE_BIT];
  assign decoder_on = control_q[lf_status_pkg::DECODER_ENABLE_BIT];
  assign count_ok = !control_q[lf_status_pkg::TOGGLE_MODE_BIT];

  // ------------------------------------------------------------
  // acknowledge bit
  // ------------------------------------------------------------
  logic ack_clear;
  // the acknowledge is a one-cycle write strobe with no storage, so reset cannot touch it
  assign ack_clear = status_wr && i_hwdata[lf_status_pkg::ACKNOWLEDGE_BIT];

  // ------------------------------------------------------------
  // flag set events
  // ------------------------------------------------------------
  logic set_dr;
  logic set_er;
  logic set_cd;
  logic set_id;
  logic set_ov;
  logic set_eom;
  assign set_dr = decoder_on && data_mode && i_rx_events.byte_done;
  assign set_er = decoder_on && data_mode && i_rx_events.manchester_error;
  assign set_cd = !data_mode && count_ok && i_rx_events.carrier_valid;
  assign set_id = decoder_on && data_mode && i_rx_events.id_match;
  // a data register read in the same cycle as the new byte keeps overflow from setting
  assign set_ov = set_dr && flags_q.data_ready && !data_rd;
  assign set_eom = decoder_on && data_mode && i_rx_events.eom_error &&
                   (flags_q.data_ready || set_dr);

  // ------------------------------------------------------------
  // event flags
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      flags_q <= lf_status_pkg::FLAGS_RESET;
    end else begin
      // set wins over the acknowledge in the same cycle
      flags_q.data_ready <= set_dr || (flags_q.data_ready && !ack_clear && !data_rd);
      flags_q.receive_error <= set_er || (flags_q.receive_error && !ack_clear);
      flags_q.carrier_detect <= set_cd || (flags_q.carrier_detect && !ack_clear);
      flags_q.id_match <= set_id || (flags_q.id_match && !ack_clear);
      flags_q.overflow <= set_ov || (flags_q.overflow && !ack_clear);
      flags_q.end_of_message <= set_eom || (flags_q.end_of_message && !ack_clear);
      if (!data_mode) begin
        flags_q.receive_error <= 1'b0;
        flags_q.overflow <= 1'b0;
        flags_q.end_of_message <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // received byte holding register
  // ------------------------------------------------------------
  // bits gathered before an error still land here when the byte strobe comes
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      rx_data_q <= 8'h00;
    end else if (set_dr) begin
      rx_data_q <= i_rx_byte;
    end
  end

  // ------------------------------------------------------------
  // software settings
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      low_power_sniff_q <= lf_status_pkg::LOW_POWER_SNIFF_RESET;
    end else if (status_wr) begin
      low_power_sniff_q <= i_hwdata[lf_status_pkg::LOW_POWER_SNIFF_BIT];
    end
  end

  // control register stays reachable on every page so software can flip the page back
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      control_q <= lf_status_pkg::CONTROL_RESET;
    end else if (wr_phase && hit(addr_q, lf_status_pkg::CONTROL_OFFSET)) begin
      control_q <= i_hwdata[3:0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      irq_en_q <= lf_status_pkg::IRQ_ENABLE_RESET;
    end else if (wr_phase && hit(addr_q, lf_status_pkg::IRQ_ENABLE_OFFSET)) begin
      irq_en_q <= i_hwdata[2:0];
    end
  end

  assign o_control = control_q;

  // ------------------------------------------------------------
  // interrupt request
  // ------------------------------------------------------------
  // overflow and end-of-message ride on the data ready request
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= (flags_q.data_ready && irq_en_q[lf_status_pkg::DATA_READY_IE_BIT]) ||
               (flags_q.receive_error && irq_en_q[lf_status_pkg::ERROR_IE_BIT]) ||
               (flags_q.id_match && irq_en_q[lf_status_pkg::ID_MATCH_IE_BIT]);
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0000_0000;
    if (page0 && hit(addr_q, lf_status_pkg::STATUS_OFFSET)) begin
      rdata[7:2] = flags_q;
      rdata[lf_status_pkg::LOW_POWER_SNIFF_BIT] = low_power_sniff_q;
      rdata[lf_status_pkg::ACKNOWLEDGE_BIT] = 1'b0;
    end else if (page0 && hit(addr_q, lf_status_pkg::DATA_OFFSET)) begin
      rdata[7:0] = rx_data_q;
    end else if (hit(addr_q, lf_status_pkg::CONTROL_OFFSET)) begin
      rdata[3:0] = control_q;
    end else if (hit(addr_q, lf_status_pkg::IRQ_ENABLE_OFFSET)) begin
      rdata[2:0] = irq_en_q;
    end
  end

  // data phase output must appear in the data phase itself, so it is a mux of flops
  assign o_hrdata = rd_phase ? rdata : 32'h0000_0000;

  // ------------------------------------------------------------
  // sniff transition timer
  // ------------------------------------------------------------
  lf_sniff_delay #(
    .EXTRA_CYCLES(SNIFF_CYCLES)
  ) u_sniff (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_low_power_sniff(low_power_sniff_q),
    .i_transition_req(i_transition_req),
    .o_transition_done(o_transition_done)
  );

endmodule : lf_receiver_status_flags

/* bench/lf_receiver_status_flags_chk.sv */
// checker: acknowledge, page, irq and transition properties of the status block
`timescale 1ns/1ps
module lf_receiver_status_flags_chk #(
  parameter int SNIFF_CYCLES = 8
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // bus
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic [31:0] o_hrdata,
  // receiver side
  input wire lf_status_pkg::rx_events_t i_rx_events,
  input wire logic i_transition_req,
  input wire logic o_irq,
  input wire logic o_transition_done,
  input wire logic [3:0] o_control
);
  localparam int done_max = SNIFF_CYCLES + 3;
  logic [2:0] sel_q;
  logic st_hit;
  logic calm;
  assign st_hit = i_hsel && i_htrans[1] && i_haddr[7:0] == lf_status_pkg::STATUS_OFFSET;
  // a transfer in the last three cycles may still move page, mode or enables
  assign calm = !i_hsel && sel_q == 3'h0;
  always_ff @(posedge i_ref_clk) begin
    sel_q <= {sel_q[1:0], i_hsel};
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  a_ack_reads_zero: assert property (st_hit && !i_hwrite |=> !o_hrdata[0])
    else $error("acknowledge bit read back as one");
  a_page_hides: assert property (st_hit && !i_hwrite && o_control[0] && !sel_q[1]
    |=> o_hrdata == 32'h0000_0000) else $error("status visible on page one");
  a_ack_clears: assert property ((st_hit && i_hwrite && !o_control[0] && !sel_q[1])
    ##1 (i_hwdata[0] && i_rx_events == 5'h00) ##1 (i_rx_events == 5'h00) |=> !o_irq)
    else $error("acknowledge left a request standing");
  a_zero_ack_keeps: assert property ((st_hit && i_hwrite && !o_control[0] && !sel_q[1]
    && o_irq) ##1 !i_hwdata[0] |-> ##2 o_irq) else $error("zero acknowledge cleared flags");
  a_decoder_quiet: assert property (calm && !o_control[2] && !o_irq |=> !o_irq)
    else $error("request raised with decoder off");
  a_carrier_no_err: assert property (calm && o_control[1] && !o_irq
    && ($past(i_rx_events) & 5'h12) == 5'h00 |=> !o_irq) else $error("error in carrier mode");
  a_trans_bound: assert property (i_transition_req |-> ##[1:done_max] o_transition_done)
    else $error("transition never completed");
  a_reset_clear: assert property ($past(i_srst) |-> !o_irq && o_control == 4'h4)
    else $error("reset state wrong");
endmodule : lf_receiver_status_flags_chk

bind lf_receiver_status_flags lf_receiver_status_flags_chk #(.SNIFF_CYCLES(SNIFF_CYCLES)) chk_u (
  .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_hsel(i_hsel), .i_haddr(i_haddr),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .o_hrdata(o_hrdata),
  .i_rx_events(i_rx_events), .i_transition_req(i_transition_req), .o_irq(o_irq),
  .o_transition_done(o_transition_done), .o_control(o_control)
);

/* bench/test_lf_receiver_status_flags.sv */
// testbench: bus, flag, acknowledge and transition checks of the status block
`timescale 1ns/1ps
module test_lf_receiver_status_flags;
  localparam int sniff_n = 8;
  logic i_ref_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_hsel = 1'b0;
  logic [31:0] i_haddr = 32'h0000_0000;
  logic [1:0] i_htrans = 2'h0;
  logic i_hwrite = 1'b0;
  logic [31:0] i_hwdata = 32'h0000_0000;
  logic i_transition_req = 1'b0;
  lf_status_pkg::rx_events_t i_rx_events = 5'h00;
  logic [7:0] i_rx_byte = 8'h00;
  logic [31:0] o_hrdata;
  logic o_hreadyout;
  logic o_irq;
  logic o_transition_done;
  logic [3:0] o_control;
  logic [31:0] exp_q[$];
  logic rd_pend = 1'b0;
  logic [7:0] b = 8'h00;
  int mismatches = 0;
  int tests_run = 0;

  always #5 i_ref_clk = ~i_ref_clk;

  lf_receiver_status_flags #(.SNIFF_CYCLES(sniff_n)) dut_u (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2), .i_hwdata(i_hwdata),
    .i_hready(o_hreadyout), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(),
    .i_rx_events(i_rx_events), .i_rx_byte(i_rx_byte), .i_transition_req(i_transition_req),
    .o_irq(o_irq), .o_transition_done(o_transition_done), .o_control(o_control)
  );

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic end_of_test();
    if (mismatches == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  // read data is judged in its data phase against the oldest note
  always @(posedge i_ref_clk) begin
    if (rd_pend) begin
      check(o_hrdata, exp_q.pop_front());
    end
    rd_pend <= i_hsel && i_htrans[1] && !i_hwrite && o_hreadyout;
  end

  task automatic rdy();
    int n;
    n = 0;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (o_hreadyout !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      end_of_test();
    end
  endtask : rdy

  // the trailing idle edge keeps page and enable changes apart from the next access
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      input logic [4:0] ev);
    logic [31:0] r;
    r = $urandom();
    i_hsel <= 1'b1;
    i_haddr <= {24'h00_0000, a};
    i_htrans <= 2'h2;
    i_hwrite <= w;
    rdy();
    i_hsel <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= {r[31:8], d};
    i_rx_events <= ev;
    rdy();
    i_rx_events <= 5'h00;
    @(posedge i_ref_clk);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d, 5'h00);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({24'h00_0000, e});
    xfer(1'b0, a, 8'h00, 5'h00);
  endtask : rd

  task automatic pulse(input logic [4:0] ev);
    b = 8'($urandom());
    i_rx_byte <= b;
    i_rx_events <= ev;
    @(posedge i_ref_clk);
    i_rx_events <= 5'h00;
    i_rx_byte <= ~b;
  endtask : pulse

  task automatic chk_irq(input logic e);
    @(posedge i_ref_clk);
    #1;
    check({31'h0000_0000, o_irq}, {31'h0000_0000, e});
    @(posedge i_ref_clk);
  endtask : chk_irq

  task automatic trans(input int exp_n);
    int n;
    n = 0;
    i_transition_req <= 1'b1;
    @(posedge i_ref_clk);
    i_transition_req <= 1'b0;
    #1;
    while (o_transition_done !== 1'b1 && n < 50) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    check(32'(n), 32'(exp_n));
    @(posedge i_ref_clk);
  endtask : trans

  initial begin
    void'($urandom(32'h1e7d));
    repeat (8) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    @(posedge i_ref_clk);
    rd(8'h00, 8'h02);
    rd(8'h04, 8'h04);
    rd(8'h0c, 8'h00);
    rd(8'h10, 8'h00);
    wr(8'h00, 8'hfd);
    rd(8'h00, 8'h00);
    trans(0);
    wr(8'h00, 8'hfe);
    rd(8'h00, 8'h02);
    trans(sniff_n);
    wr(8'h0c, 8'h07);
    pulse(5'h10);
    chk_irq(1'b1);
    rd(8'h00, 8'h82);
    rd(8'h08, b);
    rd(8'h00, 8'h02);
    wr(8'h0c, 8'h06);
    pulse(5'h10);
    pulse(5'h11);
    chk_irq(1'b0);
    rd(8'h00, 8'h8e);
    rd(8'h08, b);
    wr(8'h00, 8'h03);
    pulse(5'h08);
    chk_irq(1'b1);
    pulse(5'h02);
    rd(8'h00, 8'h52);
    wr(8'h00, 8'h02);
    chk_irq(1'b1);
    wr(8'h00, 8'h03);
    chk_irq(1'b0);
    wr(8'h0c, 8'h07);
    wr(8'h04, 8'h06);
    pulse(5'h0d);
    chk_irq(1'b0);
    rd(8'h00, 8'h22);
    wr(8'h00, 8'h03);
    wr(8'h04, 8'h0e);
    pulse(5'h04);
    rd(8'h00, 8'h02);
    wr(8'h04, 8'h00);
    pulse(5'h1a);
    chk_irq(1'b0);
    rd(8'h00, 8'h02);
    wr(8'h04, 8'h05);
    pulse(5'h10);
    rd(8'h08, 8'h00);
    rd(8'h00, 8'h00);
    wr(8'h00, 8'h03);
    wr(8'h04, 8'h04);
    rd(8'h00, 8'h82);
    rd(8'h08, b);
    xfer(1'b1, 8'h00, 8'h03, 5'h10);
    rd(8'h00, 8'h82);
    end_of_test();
  end
endmodule : test_lf_receiver_status_flags
